/* pcm_resync_map.vh */
// constants for the receive PCM resynchronizer
`ifndef PCM_RESYNC_MAP_VH
`define PCM_RESYNC_MAP_VH
`define BYTE_BITS 8
`define SWITCH_STAGES 2
`define COUNTER_RESET 8'h00
`endif

/* edge_sync.v */
// two-flop synchronizer with edge detect for an outside-domain input
`timescale 1ns/10ps
module edge_sync
(
	input wire sys_clk,
	input wire rstn,
	input wire din,
	output reg level_r,
	output wire rise,
	output wire fall
);
	reg meta_r;
	reg last_r;

	always @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			meta_r <= 1'b0;
			level_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= din;
			level_r <= meta_r;
			last_r <= level_r;
		end
	end

	assign rise = level_r & ~last_r;
	assign fall = ~level_r & last_r;
endmodule

/* pcm_receive_resync.v */
// per-sample receive PCM resynchronizer onto the transmit bit clock
`timescale 1ns/10ps
`include "pcm_resync_map.vh"
module pcm_receive_resync
#(
	parameter BITS = `BYTE_BITS
)
(
	input wire sys_clk,
	input wire rstn,
	input wire system_rx_bit_clock,
	input wire system_rx_frame_sync,
	input wire system_rx_data,
	input wire system_tx_bit_clock,
	output reg codec_bit_clock_r,
	output reg regenerated_rx_frame_sync_r,
	output reg codec_rx_data_r
);
	wire rxc_lvl;
	wire rxc_rise;
	wire rxc_fall;
	wire fs_rise;
	wire txc_lvl;
	wire txc_rise;
	wire txc_fall;
	reg rxd_meta_r;
	reg rxd_r;
	reg start_flag_r;
	reg switch_stage_a_r;
	reg switch_stage_b_r;
	reg half_cycle_delay_flop_r;
	reg [BITS-1:0] data_buffer_shifter_r;
	reg [BITS-1:0] bit_counter_shifter_r;
	wire counter_terminal_output;
	wire rx_gated;
	wire tx_gated;
	reg [BITS-1:0] bit_counter_shifter_nxt;
	reg [BITS-1:0] data_buffer_shifter_nxt;

	// fill bit enters at the lsb, so the msb leaves first
	function [BITS-1:0] shift_in;
		input [BITS-1:0] v;
		input b;
		begin
			shift_in = {v[BITS-2:0], b};
		end
	endfunction

	edge_sync u_rxc
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(system_rx_bit_clock),
		.level_r(rxc_lvl),
		.rise(rxc_rise),
		.fall(rxc_fall)
	);

	edge_sync u_fs
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(system_rx_frame_sync),
		.level_r(),
		.rise(fs_rise),
		.fall()
	);

	edge_sync u_txc
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(system_tx_bit_clock),
		.level_r(txc_lvl),
		.rise(txc_rise),
		.fall(txc_fall)
	);

	// data delayed like the receive clock so sampling stays mid bit
	always @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rxd_meta_r <= 1'b0;
			rxd_r <= 1'b0;
		end
		else
		begin
			rxd_meta_r <= system_rx_data;
			rxd_r <= rxd_meta_r;
		end
	end

	assign counter_terminal_output = bit_counter_shifter_r[BITS-1];
	// gating on edge strobes cannot glitch
	assign rx_gated = start_flag_r & rxc_fall;
	assign tx_gated = switch_stage_b_r & txc_rise;

	// terminal clears flag
	// a short frame stalls here until more receive clocks arrive
	// sync rises while busy are dropped, one byte per frame
	always @(posedge sys_clk)
	begin
		if (!rstn)
			start_flag_r <= 1'b0;
		else if (counter_terminal_output)
			start_flag_r <= 1'b0;
		else if (fs_rise)
			start_flag_r <= 1'b1;
	end

	// buffer fills on receive, drains on transmit
	// strobes are exclusive: stage b only opens once the start flag is gone
	always @*
	begin
		bit_counter_shifter_nxt = bit_counter_shifter_r;
		data_buffer_shifter_nxt = data_buffer_shifter_r;
		if (rx_gated)
		begin
			bit_counter_shifter_nxt = shift_in(bit_counter_shifter_r, 1'b1);
			data_buffer_shifter_nxt = shift_in(data_buffer_shifter_r, rxd_r);
		end
		else if (tx_gated)
		begin
			bit_counter_shifter_nxt = shift_in(bit_counter_shifter_r, 1'b0);
			data_buffer_shifter_nxt = shift_in(data_buffer_shifter_r, 1'b0);
		end
	end

	always @(posedge sys_clk)
	begin
		if (!rstn)
			bit_counter_shifter_r <= `COUNTER_RESET;
		else
			bit_counter_shifter_r <= bit_counter_shifter_nxt;
	end

	// buffer content is don't-care at reset, cleared only for clean traces
	always @(posedge sys_clk)
	begin
		if (!rstn)
			data_buffer_shifter_r <= {BITS{1'b0}};
		else
			data_buffer_shifter_r <= data_buffer_shifter_nxt;
	end

	// drift shows as a whole-bit slip here
	always @(posedge sys_clk)
	begin
		if (!rstn || !counter_terminal_output)
		begin
			switch_stage_a_r <= 1'b0;
			switch_stage_b_r <= 1'b0;
		end
		else if (txc_rise)
		begin
			switch_stage_a_r <= 1'b1;
			switch_stage_b_r <= switch_stage_a_r;
		end
	end

	// msb into delay flop on first gated rise
	always @(posedge sys_clk)
	begin
		if (!rstn)
			half_cycle_delay_flop_r <= 1'b0;
		else if (tx_gated)
			half_cycle_delay_flop_r <= data_buffer_shifter_r[BITS-1];
	end

	// all codec outputs retimed to transmit clock
	// clock, sync and data leave one register rank so they cannot skew
	// frame sync is second stage
	// delayed: sync rises one transmit bit ahead of the msb
	always @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			codec_bit_clock_r <= 1'b0;
			regenerated_rx_frame_sync_r <= 1'b0;
			codec_rx_data_r <= 1'b0;
		end
		else
		begin
			// codec bit clock follows transmit clock
			codec_bit_clock_r <= txc_lvl;
			regenerated_rx_frame_sync_r <= switch_stage_b_r;
			codec_rx_data_r <= half_cycle_delay_flop_r;
		end
	end
endmodule

/* pcm_receive_resync_checker.sv */
// port assertions for the receive resynchronizer
`timescale 1ns/10ps
module pcm_receive_resync_checker
(
	input wire sys_clk,
	input wire rstn,
	input wire system_tx_bit_clock,
	input wire codec_bit_clock_r,
	input wire regenerated_rx_frame_sync_r,
	input wire codec_rx_data_r
);
	reg [7:0] hi_r;
	wire fs = regenerated_rx_frame_sync_r;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence fs_up;
		$rose(fs);
	endsequence
	always @(posedge sys_clk)
		hi_r <= fs ? hi_r + 8'h01 : 8'h00;
	a_clock_copy: assert property ($past(rstn, 3) && $past(rstn, 2)
		|-> codec_bit_clock_r == $past(system_tx_bit_clock, 3)) else $error("codec clock lag");
	a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !fs && !codec_rx_data_r)
		else $error("output during reset");
	a_fs_width: assert property ($fell(fs) |-> hi_r >= 8'd60 && hi_r <= 8'd68)
		else $error("sync width");
	a_fs_max: assert property (fs |-> hi_r < 8'd70) else $error("sync too long");
	a_data_steady: assert property ($fell(codec_bit_clock_r) && fs |-> $stable(codec_rx_data_r))
		else $error("data moved at codec sample");
	a_fs_on_rise: assert property (fs_up |-> codec_bit_clock_r)
		else $error("sync not on tx rise");
	a_fs_gap: assert property ($fell(fs) |=> !fs [*8]) else $error("sync retrigger");
	a_fs_hold: assert property (fs_up |=> fs [*8]) else $error("sync too short");
endmodule

/* pcm_bus_model.sv */
// far side: pcm bus source and codec receive port
`timescale 1ns/10ps
module pcm_bus_model
(
	input wire clk,
	output reg rx_clk,
	output reg rx_fs,
	output reg rx_data,
	output reg tx_clk,
	input wire cclk,
	input wire cfs,
	input wire cdata,
	output reg [7:0] got
);
	reg arm;
	reg [1:0] tdiv;
	initial
		{rx_clk, rx_fs, rx_data, tx_clk, got, arm, tdiv} = 15'h0000;
	// tx clock runs free as master clock, 320 ns period
	always @(posedge clk)
	begin
		tdiv <= tdiv + 2'h1;
		if (tdiv == 2'h3)
			tx_clk <= ~tx_clk;
	end
	// sync seen at rise, bit taken at fall
	always @(posedge cclk)
		arm <= cfs;
	always @(negedge cclk)
		if (arm === 1'b1)
			got <= {got[6:0], cdata};
	// h is the half period of the receive clock in clk cycles
	task send(input [7:0] b, input integer h);
		integer i;
		begin
			rx_fs <= 1'b1;
			for (i = 7; i >= 0; i = i - 1)
			begin
				rx_data <= b[i];
				rx_clk <= 1'b1;
				repeat (h) @(posedge clk);
				rx_clk <= 1'b0;
				repeat (h) @(posedge clk);
			end
			rx_fs <= 1'b0;
		end
	endtask
endmodule

/* test_pcm_receive_resync.sv */
// self-checking bench for the receive resynchronizer
`timescale 1ns/10ps
bind pcm_receive_resync pcm_receive_resync_checker chk (.*);
module test_pcm_receive_resync;
	reg sys_clk = 1'b0;
	reg rstn = 1'b0;
	reg [7:0] v;
	wire rxc, rxf, rxd, txc, cclk, cfs, cd;
	wire [7:0] got;
	integer err_count = 0, n_checks = 0, k, w;
	always #20 sys_clk = ~sys_clk;
	pcm_bus_model m (.clk(sys_clk), .rx_clk(rxc), .rx_fs(rxf), .rx_data(rxd), .tx_clk(txc),
		.cclk(cclk),
		.cfs(cfs), .cdata(cd), .got(got));
	pcm_receive_resync uut (.sys_clk(sys_clk), .rstn(rstn), .system_rx_bit_clock(rxc),
		.system_rx_frame_sync(rxf), .system_rx_data(rxd), .system_tx_bit_clock(txc),
		.codec_bit_clock_r(cclk), .regenerated_rx_frame_sync_r(cfs), .codec_rx_data_r(cd));
	task check(input [7:0] seen, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp)
			begin
				err_count = err_count + 1;
				$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task frame(input [7:0] b, input integer h);
		begin
			@(posedge sys_clk);
			m.send(b, h);
			w = 0;
			while (cfs !== 1'b1 && w < 300)
			begin
				@(posedge sys_clk);
				w = w + 1;
			end
			if (cfs !== 1'b1)
			begin
				err_count = err_count + 1;
				conclude;
			end
			while (cfs !== 1'b0 && w < 600)
			begin
				@(posedge sys_clk);
				w = w + 1;
			end
			if (w > 599)
			begin
				err_count = err_count + 1;
				conclude;
			end
			repeat (20) @(posedge sys_clk);
			check(got, b);
			check({7'h00, cfs}, 8'h00);
		end
	endtask
	initial
	begin
		k = $urandom(32'h110e);
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check({7'h00, cfs}, 8'h00);
		for (k = 0; k < 12; k = k + 1)
		begin
			v = k < 4 ? 8'h80 >> (k * 7) | {8{k == 2}} : $urandom;
			frame(v, k % 2 ? 7 : 4);
			$display("frame %0d done", k);
		end
		conclude;
	end
endmodule
